// File: design/acq_pkg.sv
// shared constants and carrier types for the acquisition controller
package acq_pkg;
  localparam int unsigned ACQ_FIFO_W = 16;  // buffer count width
  localparam int unsigned ACQ_NCH = 12;  // channel count
  localparam int unsigned ACQ_CH_W = 4;  // channel index width
  localparam logic [31:0] ACQ_BUF_LOCAL_ADDR = 32'h0000_0030;  // buffer addr
  localparam logic [2:0] EVT_INIT_DONE = 3'h0;  // init complete
  localparam logic [2:0] EVT_CAL_DONE = 3'h1;  // calibration complete
  localparam logic [2:0] EVT_SETTLED = 3'h2;  // channels settled
  localparam logic [2:0] EVT_THR_RISE = 3'h3;  // threshold flag rising
  localparam logic [2:0] EVT_THR_FALL = 3'h4;  // threshold flag falling
  localparam logic [2:0] EVT_SEL_RST = 3'h0;  // event select reset value
  localparam logic [1:0] DISCARD_SCANS = 2'h2;  // scans dropped after start
  localparam logic [7:0] ALIGN_CYCLES = 8'h10;  // converter sync hold time

  // board control inputs from the host side
  typedef struct packed {
    logic [2:0] evt_sel;  // event select
    logic       pend_wr;  // write strobe for pending flag
    logic       pend_wdata;  // written pending value
    logic       free_scan;  // free-scan control
    logic       flush_on_sync;  // clear buffer on sync
    logic       sync_trigger_cmd;  // sync_trigger_cmd (initiator)
    logic       ext_sync;  // sync pulse from cabled initiator
  } board_ctrl_t;

  // demand dma status from the buffer
  typedef struct packed {
    logic                  demand_en;  // demand mode enabled
    logic [ACQ_FIFO_W-1:0] level;  // values in buffer
    logic [ACQ_FIFO_W-1:0] threshold;  // programmed threshold
    logic                  rd;  // one value read this cycle
  } dma_stat_t;
endpackage : acq_pkg

// File: design/acq_dma_req.sv
// demand-mode dma request generator
`timescale 1ns/10ps
`default_nettype none
module acq_dma_req (
  input  wire logic              clk,  // master clock
  input  wire logic              rst,  // async reset
  input  wire acq_pkg::dma_stat_t st,  // buffer status
  input  wire logic              buf_clr,  // buffer cleared
  input  wire logic              cal_run,  // calibration running
  output logic                   dreq_q  // dma request
);
  logic [acq_pkg::ACQ_FIFO_W:0] nread_q;  // values read in this burst
  logic                         stop;  // termination condition

  // first terminating event drops the request
  assign stop = (st.level == '0) || buf_clr || cal_run ||
      (nread_q == ({1'b0, st.threshold} + 1'b1));

  // request once level exceeds threshold; count reads while active
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dreq_q  <= 1'b0;
      nread_q <= '0;
    end else if (dreq_q) begin
      if (stop) begin
        dreq_q  <= 1'b0;
        nread_q <= '0;
      end else if (st.rd) begin
        nread_q <= nread_q + 1'b1;
        if (nread_q + 1'b1 == {1'b0, st.threshold} + 1'b1)
          dreq_q <= 1'b0;
      end
    end else if (st.demand_en && st.level > st.threshold && !buf_clr &&
        !cal_run) begin
      dreq_q  <= 1'b1;
      nread_q <= '0;  // a burst ended by its read count starts afresh
    end
  end

  AST_DREQ_START: assert property (@(posedge clk) disable iff (rst)
      (!dreq_q && st.demand_en && st.level > st.threshold && !buf_clr &&
       !cal_run) |=> dreq_q)
    else $error("dma request not raised");
  AST_DREQ_STOP: assert property (@(posedge clk) disable iff (rst)
      (dreq_q && (buf_clr || cal_run || st.level == '0)) |=> !dreq_q)
    else $error("dma request not dropped");
endmodule : acq_dma_req
`default_nettype wire

// File: design/acq_event_sync.sv
// event interrupt, demand dma and scan synchronization controller
`timescale 1ns/10ps
`default_nettype none
module acq_event_sync (
  input  wire logic                 clk,  // master clock 125 MHz
  input  wire logic                 rst,  // async reset, high
  input  wire acq_pkg::board_ctrl_t ctrl,  // board control bits
  input  wire acq_pkg::dma_stat_t   dma_st,  // buffer status for dma
  input  wire logic                 init_done,  // initialization finished
  input  wire logic                 cal_run,  // calibration running
  input  wire logic                 thr_flag,  // buffer threshold flag
  input  wire logic                 scan_start,  // one scan boundary pulse
  input  wire logic                 pci_int_en,  // bridge interrupt enable
  input  wire logic                 pci_lint_en,  // bridge local int enable
  input  wire logic [1:0]           grp_en,  // channel group enables
  input  wire logic [1:0]           grp_clk,  // group sample clocks
  output logic                      lint_q,  // local interrupt request
  output logic                      pend_q,  // pending flag readback
  output logic                      host_int_q,  // host bus interrupt
  output logic                      settled_q,  // channels-settled flag
  output logic                      buf_clr_q,  // buffer clear pulse
  output logic                      store_en_q,  // samples may be stored
  output logic                      sync_mode_q,  // scan-synchronized
  output logic [1:0]                ch_clk_q,  // clock per group
  output logic [acq_pkg::ACQ_CH_W-1:0] ch_idx_q,  // channel slot in scan
  output logic                      dreq_q,  // dma request
  output logic [31:0]               dma_laddr_q  // dma local address
);
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_DIST  = 5'b00010,
    S_ALIGN = 5'b00100,
    S_SCAN  = 5'b01000,
    S_DROP  = 5'b10000
  } sync_st_t;

  sync_st_t   st_q;
  logic [7:0] cnt_q;  // align counter
  logic [1:0] drop_q;  // scans discarded
  logic       free_q;  // last free-scan value
  logic       init_q;  // init done delayed
  logic       cal_q;  // cal run delayed
  logic       set_q;  // settled delayed
  logic       thr_q;  // threshold delayed
  logic [2:0] sel_q;  // select delayed
  logic       cond_now;
  logic       cond_old;
  logic       hit;
  logic       sync_go;

  // condition for a given select code from current or delayed levels
  function automatic logic evt_cond(input logic [2:0] s, input logic i,
      input logic c, input logic t, input logic h);
    case (s)
      acq_pkg::EVT_INIT_DONE: evt_cond = i;
      acq_pkg::EVT_CAL_DONE:  evt_cond = c;
      acq_pkg::EVT_SETTLED:   evt_cond = t;
      acq_pkg::EVT_THR_RISE:  evt_cond = h;
      acq_pkg::EVT_THR_FALL:  evt_cond = !h;
      default:                evt_cond = 1'b0;  // reserved raise nothing
    endcase
  endfunction : evt_cond

  // edge detect only while the same code stays selected; an init_done rise hits under any code
  assign cond_now = evt_cond(ctrl.evt_sel, init_done, !cal_run, settled_q,
      thr_flag);
  assign cond_old = evt_cond(sel_q, init_q, !cal_q, set_q, thr_q);
  assign hit = cond_now && !cond_old && (sel_q == ctrl.evt_sel) ||
      (init_done && !init_q);

  // history registers for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_q <= 1'b0;
      cal_q  <= 1'b0;
      set_q  <= 1'b0;
      thr_q  <= 1'b0;
      sel_q  <= acq_pkg::EVT_SEL_RST;
    end else begin
      init_q <= init_done;
      cal_q  <= cal_run;
      set_q  <= settled_q;
      thr_q  <= thr_flag;
      sel_q  <= ctrl.evt_sel;
    end
  end

  // pending flag: event wins over host clear; writing one keeps it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (hit) begin
      pend_q <= 1'b1;
    end else if (ctrl.pend_wr && !ctrl.pend_wdata) begin
      pend_q <= 1'b0;
    end
  end

  // single request line and gated host interrupt follow the flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lint_q     <= 1'b0;
      host_int_q <= 1'b0;
    end else begin
      lint_q     <= pend_q;
      host_int_q <= pend_q && pci_int_en && pci_lint_en;
    end
  end

  // sync start: free-scan falling, or software/external sync
  assign sync_go = (free_q && !ctrl.free_scan) ||
      (!ctrl.free_scan && (ctrl.sync_trigger_cmd || ctrl.ext_sync));

  // scan synchronization sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= S_DIST;  // synchronized by default
      free_q    <= 1'b0;
      cnt_q     <= '0;
      drop_q    <= '0;
      settled_q <= 1'b0;
      buf_clr_q <= 1'b0;
      store_en_q <= 1'b0;
    end else begin
      free_q    <= ctrl.free_scan;
      buf_clr_q <= 1'b0;
      if (ctrl.free_scan) begin
        st_q       <= S_IDLE;
        settled_q  <= 1'b1;
        store_en_q <= 1'b1;
      end else if (sync_go) begin
        st_q       <= S_DIST;
        settled_q  <= 1'b0;
        store_en_q <= 1'b0;
        buf_clr_q  <= (free_q && !ctrl.free_scan) ||
            ctrl.flush_on_sync;
      end else begin
        case (st_q)
          S_IDLE: st_q <= S_DIST;
          S_DIST: begin
            cnt_q <= '0;
            st_q  <= S_ALIGN;
          end
          S_ALIGN: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == acq_pkg::ALIGN_CYCLES) begin
              drop_q    <= '0;
              buf_clr_q <= 1'b1;
              st_q      <= S_DROP;
            end
          end
          S_DROP: begin
            if (scan_start) begin
              drop_q <= drop_q + 1'b1;
              if (drop_q + 1'b1 == acq_pkg::DISCARD_SCANS) begin
                st_q       <= S_SCAN;
                settled_q  <= 1'b1;
                store_en_q <= 1'b1;
              end
            end
          end
          S_SCAN: st_q <= S_SCAN;
          default: st_q <= S_DIST;
        endcase
      end
    end
  end

  // group clocks: group 0 feeds all enabled groups when synchronized
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_mode_q <= 1'b1;
      ch_clk_q    <= '0;
    end else begin
      sync_mode_q <= !ctrl.free_scan;
      if (!ctrl.free_scan)
        ch_clk_q <= grp_en & {2{grp_clk[0]}};
      else
        ch_clk_q <= grp_en & grp_clk;
    end
  end

  // channel slot restarts at the lowest channel each scan
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_idx_q <= '0;
    end else if (scan_start) begin
      ch_idx_q <= '0;
    end else if (ch_idx_q != acq_pkg::ACQ_CH_W'(acq_pkg::ACQ_NCH - 1)) begin
      ch_idx_q <= ch_idx_q + 1'b1;
    end
  end

  // fixed dma source address
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      dma_laddr_q <= '0;
    else
      dma_laddr_q <= acq_pkg::ACQ_BUF_LOCAL_ADDR;
  end

  acq_dma_req u_dma (
    .clk     (clk),
    .rst     (rst),
    .st      (dma_st),
    .buf_clr (buf_clr_q),
    .cal_run (cal_run),
    .dreq_q  (dreq_q)
  );

  sequence s_start;
    !ctrl.free_scan && free_q;
  endsequence
  sequence s_cleared;
    ##1 buf_clr_q;
  endsequence

  AST_START_CLEARS: assert property (@(posedge clk) disable iff (rst)
      s_start |-> s_cleared)
    else $error("buffer not cleared at sync start");
  AST_SETTLE_LOW: assert property (@(posedge clk) disable iff (rst)
      s_start |=> !settled_q [*3])
    else $error("settled not low during sequence");
  AST_FREE_MODE: assert property (@(posedge clk) disable iff (rst)
      ctrl.free_scan |=> !sync_mode_q && settled_q)
    else $error("free scan not honoured");
  AST_PEND_SET: assert property (@(posedge clk) disable iff (rst)
      hit |=> pend_q ##1 lint_q)
    else $error("pending flag not set");
  AST_PEND_HOLD: assert property (@(posedge clk) disable iff (rst)
      (pend_q && !(ctrl.pend_wr && !ctrl.pend_wdata)) |=> pend_q)
    else $error("pending flag lost");
  // a reserved select with no init edge must leave the flag clear
  AST_RESERVED: assert property (@(posedge clk) disable iff (rst)
      (!pend_q && ctrl.evt_sel > acq_pkg::EVT_THR_FALL &&
       !(init_done && !init_q)) |=> !pend_q)
    else $error("reserved code raised event");
  AST_HOST_INT: assert property (@(posedge clk) disable iff (rst)
      host_int_q == ($past(pend_q) && $past(pci_int_en) &&
      $past(pci_lint_en)))
    else $error("host interrupt not gated by both enables");
  AST_GROUP_CLK: assert property (@(posedge clk) disable iff (rst)
      (!ctrl.free_scan && grp_en == 2'h3) |=>
      ch_clk_q == {2{$past(grp_clk[0])}})
    else $error("group 0 clock not distributed");
endmodule : acq_event_sync
`default_nettype wire

// File: dv/acq_host_model.sv
// host-side model that services the local request by writing the flag
`timescale 1ns/10ps
`default_nettype none
module acq_host_model #(
  parameter int DLY = 3  // cycles from seen request to the write
) (
  input  wire logic clk,   // master clock
  input  wire logic rst,   // async reset
  input  wire logic go,    // service requests while high
  input  wire logic wval,  // value to write into the flag
  input  wire logic lint,  // local request from the device
  output logic      wr,    // one-cycle write strobe
  output logic      wd     // written value
);
  logic [3:0] cnt_q;
  // wait the latency, then one strobe; data idles at the inverse value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      wr    <= 1'b0;
      wd    <= 1'b1;
    end else begin
      wr <= 1'b0;
      wd <= ~wval;
      if (go && lint && cnt_q == 4'h0) begin
        cnt_q <= 4'(DLY);
      end else if (cnt_q == 4'h1) begin
        wr    <= 1'b1;
        wd    <= wval;
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : acq_host_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the event, dma and scan sync controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] src;
    logic       val;
    logic [1:0] en;
    logic       exp;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, init_done = 1'b0, cal_run = 1'b0;
  logic thr_flag = 1'b0, scan_start = 1'b0, go = 1'b0, wval = 1'b0;
  logic [1:0] ien = 2'h3, grp_en = 2'h3, grp_clk = 2'h1;
  logic [7:0] sc_q = 8'h00;
  acq_pkg::board_ctrl_t c = '0;
  acq_pkg::board_ctrl_t ctrl;
  acq_pkg::dma_stat_t   ds = '0;
  logic h_wr, h_wd, lint_q, pend_q, host_int_q, settled_q, buf_clr_q;
  logic store_en_q, sync_mode_q, dreq_q;
  logic [1:0]  ch_clk_q;
  logic [31:0] dma_laddr_q;
  logic [3:0]  ch_idx_q;
  int n_errors = 0, compares = 0, k, nclr;
  row_t rows [12] = '{'{3'h3, 2'h2, 1'b1, 2'h3, 1'b1},
    '{3'h4, 2'h2, 1'b0, 2'h3, 1'b1}, '{3'h4, 2'h2, 1'b1, 2'h1, 1'b0},
    '{3'h3, 2'h2, 1'b0, 2'h3, 1'b0}, '{3'h5, 2'h2, 1'b1, 2'h3, 1'b0},
    '{3'h6, 2'h2, 1'b0, 2'h3, 1'b0}, '{3'h7, 2'h2, 1'b1, 2'h3, 1'b0},
    '{3'h1, 2'h1, 1'b1, 2'h3, 1'b0}, '{3'h1, 2'h1, 1'b0, 2'h2, 1'b1},
    '{3'h0, 2'h0, 1'b0, 2'h3, 1'b0}, '{3'h3, 2'h0, 1'b1, 2'h3, 1'b1},
    '{3'h0, 2'h2, 1'b0, 2'h3, 1'b0}};
  // clock, periodic scan boundary and control word assembly
  always #4 clk = ~clk;
  always @(posedge clk) begin
    sc_q       <= sc_q + 8'h01;
    scan_start <= (sc_q[3:0] == 4'hf);
  end
  always_comb begin
    ctrl            = c;
    ctrl.pend_wr    = h_wr;
    ctrl.pend_wdata = h_wd;
  end
  acq_host_model u_acq_host_model (.clk, .rst, .go, .wval,
    .lint(lint_q), .wr(h_wr), .wd(h_wd));
  acq_event_sync u_acq_event_sync (.clk, .rst, .ctrl, .dma_st(ds),
    .init_done, .cal_run, .thr_flag, .scan_start, .pci_int_en(ien[1]),
    .pci_lint_en(ien[0]), .grp_en, .grp_clk, .lint_q, .pend_q,
    .host_int_q, .settled_q, .buf_clr_q, .store_en_q, .sync_mode_q,
    .ch_clk_q, .ch_idx_q, .dreq_q, .dma_laddr_q);
  // comparisons
  task automatic cmp_bit(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp_word
  // host model writes a value into the pending flag
  task automatic host_wr(logic v);
    @(posedge clk);
    go   <= 1'b1;
    wval <= v;
    repeat (12) @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
  endtask : host_wr
  // count clear pulses until settled rises, bounded
  task automatic wait_settle();
    int i;
    nclr = 0;
    for (i = 0; i < 2000; i++) begin
      @(negedge clk);
      if (buf_clr_q === 1'b1) nclr++;
      if (settled_q === 1'b1 && i > 2) break;
    end
    cmp_bit("settled_q", 1'b1, settled_q);
  endtask : wait_settle
  // one sync pulse, from the initiator's trigger or the cable, then settle
  task automatic sync_run(logic fl, logic ext);
    @(posedge clk);
    c.flush_on_sync    <= fl;
    c.sync_trigger_cmd <= !ext;
    c.ext_sync         <= ext;
    @(posedge clk);
    c.sync_trigger_cmd <= 1'b0;
    c.ext_sync         <= 1'b0;
    wait_settle();
    @(posedge clk);
    c.flush_on_sync <= 1'b0;
  endtask : sync_run
  task automatic dma_case(logic [15:0] lv, int nrd, logic cal, logic e);
    @(posedge clk);
    ds.demand_en <= 1'b1;
    ds.threshold <= 16'h0004;
    ds.level     <= lv;
    repeat (3) @(posedge clk);
    repeat (nrd) begin
      ds.rd    <= 1'b1;
      ds.level <= ds.level - 16'h0001;  // each read drains one value
      @(posedge clk);
      ds.rd <= 1'b0;
      @(posedge clk);
    end
    cal_run <= cal;
    repeat (3) @(negedge clk);
    cmp_bit("dreq_q", e, dreq_q);
    @(posedge clk);
    ds.level <= 16'h0000;
    cal_run  <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_bit("dreq_q empty", 1'b0, dreq_q);
  endtask : dma_case
  task automatic end_sim();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge clk);
    cmp_bit("sync_mode_q rst", 1'b1, sync_mode_q);
    cmp_bit("pend_q rst", 1'b0, pend_q);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    init_done <= 1'b1;
    wait_settle();
    cmp_bit("pend_q init", 1'b1, pend_q);
    cmp_word("dma_laddr_q", 32'h0000_0030, dma_laddr_q);
    host_wr(1'b1);
    cmp_bit("pend_q wr1", 1'b1, pend_q);
    host_wr(1'b0);
    // table of event selections, enables and expected requests
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      c.evt_sel <= rows[k].sel;
      ien       <= rows[k].en;
      repeat (3) @(posedge clk);
      case (rows[k].src)
        2'h0: init_done <= rows[k].val;
        2'h1: cal_run <= rows[k].val;
        default: thr_flag <= rows[k].val;
      endcase
      repeat (4) @(negedge clk);
      cmp_bit("pend_q", rows[k].exp, pend_q);
      cmp_bit("lint_q", rows[k].exp, lint_q);
      cmp_bit("host_int_q", rows[k].exp & (rows[k].en == 2'h3),
              host_int_q);
      host_wr(1'b0);
      cmp_bit("pend_q clr", 1'b0, pend_q);
      cmp_bit("lint_q clr", 1'b0, lint_q);
    end
    // free-scan set then clear restarts the settle sequence
    @(posedge clk);
    c.evt_sel   <= 3'h2;
    c.free_scan <= 1'b1;
    repeat (3) @(negedge clk);
    cmp_bit("sync_mode_q free", 1'b0, sync_mode_q);
    @(posedge clk);
    c.free_scan <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_bit("settled_q low", 1'b0, settled_q);
    cmp_bit("store_en_q low", 1'b0, store_en_q);
    wait_settle();
    cmp_bit("store_en_q", 1'b1, store_en_q);
    repeat (2) @(negedge clk);
    cmp_bit("pend_q settled", 1'b1, pend_q);
    cmp_bit("sync_mode_q", 1'b1, sync_mode_q);
    // channel slot restarts at the lowest channel on each scan boundary
    while (scan_start !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmp_word("ch_idx_q first", 32'h0, 32'(ch_idx_q));
    @(negedge clk);
    cmp_word("ch_idx_q next", 32'h1, 32'(ch_idx_q));
    repeat (12) @(negedge clk);
    cmp_word("ch_idx_q last", 32'hb, 32'(ch_idx_q));
    repeat (3) @(negedge clk);
    cmp_word("ch_clk_q", 32'h3, 32'(ch_clk_q));
    @(posedge clk);
    grp_en <= 2'h1;
    repeat (3) @(negedge clk);
    cmp_word("ch_clk_q dis", 32'h1, 32'(ch_clk_q));
    host_wr(1'b0);
    // cabled sync without flush: only the alignment clear
    sync_run(1'b0, 1'b1);
    cmp_word("nclr ext", 32'h1, 32'(nclr));
    // initiator sync with flush-on-sync: start clear plus alignment clear
    sync_run(1'b1, 1'b0);
    cmp_word("nclr flush", 32'h2, 32'(nclr));
    // demand dma requests and their stop events
    dma_case(16'h0004, 0, 1'b0, 1'b0);
    dma_case(16'h0005, 0, 1'b0, 1'b1);
    dma_case(16'h0005, 4, 1'b0, 1'b1);
    dma_case(16'h0005, 5, 1'b0, 1'b0);
    dma_case(16'h0007, 5, 1'b0, 1'b0);
    dma_case(16'h0005, 0, 1'b1, 1'b0);
    // global clear repeated after calibration
    sync_run(1'b1, 1'b0);
    cmp_word("nclr recal", 32'h2, 32'(nclr));
    // second reset in mid-run drops the request
    @(posedge clk);
    ds.level <= 16'h0009;
    repeat (3) @(negedge clk);
    cmp_bit("dreq_q up", 1'b1, dreq_q);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    cmp_bit("dreq_q rst", 1'b0, dreq_q);
    cmp_bit("sync_mode_q rst2", 1'b1, sync_mode_q);
    // release again: settle sequence restarts, request comes back
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit("settled_q rst2", 1'b0, settled_q);
    cmp_bit("dreq_q rst2", 1'b1, dreq_q);
    wait_settle();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
